/* hw/ppr_map.svh */
// constants for the peripheral pin remap block
`ifndef PPR_MAP_SVH
`define PPR_MAP_SVH

`define PPR_NUM_PINS   16
`define PPR_NUM_IN     8
`define PPR_NUM_OUT    8
`define PPR_NUM_FIXED  2
`define PPR_SEL_W      4
`define PPR_IDX_W      4
`define PPR_SEL_NONE   4'h0
`define PPR_SEL_RST    4'h0
`define PPR_KEY_W      8
`define PPR_KEY_FIRST  8'hA5
`define PPR_KEY_SECOND 8'h5A

`endif

/* hw/ppr_pkg.sv */
// types for the peripheral pin remap block
package ppr_pkg;

    typedef logic [3:0] ppr_sel_t;

    // routing protection state
    typedef enum logic [1:0]
    {
        PPR_OPEN   = 2'b00,
        PPR_KEY1   = 2'b01,
        PPR_LOCKED = 2'b10
    } ppr_lock_t;

endpackage : ppr_pkg

/* hw/ppr_remap.sv */
// peripheral pin remap: routing tables, protection and pin priority
`include "ppr_map.svh"

module ppr_remap
    import ppr_pkg::*;
(
    input  wire logic                             core_clk,
    input  wire logic                             rst_b,
    input  wire logic                             cfg_wr,
    input  wire logic                             cfg_dir,
    input  wire logic [`PPR_IDX_W-1:0]            cfg_idx,
    input  wire logic [`PPR_SEL_W-1:0]            cfg_val,
    input  wire logic                             key_wr,
    input  wire logic [`PPR_KEY_W-1:0]            key_val,
    input  wire logic                             lock_set,
    output logic                                  cfg_locked,
    output logic                                  cfg_err,
    input  wire logic [`PPR_NUM_PINS-1:0]         pin_in,
    input  wire logic [`PPR_NUM_PINS-1:0]         pin_analog,
    input  wire logic [`PPR_NUM_PINS-1:0]         gpio_out,
    input  wire logic [`PPR_NUM_PINS-1:0]         gpio_oe,
    output logic      [`PPR_NUM_PINS-1:0]         pin_out,
    output logic      [`PPR_NUM_PINS-1:0]         pin_oe,
    input  wire logic [`PPR_NUM_OUT-1:0]          per_out,
    output logic      [`PPR_NUM_IN-1:0]           per_in,
    input  wire logic [`PPR_NUM_FIXED-1:0]        fixed_in,
    input  wire logic [`PPR_NUM_FIXED-1:0]        fixed_analog,
    input  wire logic [`PPR_NUM_FIXED-1:0]        fixed_per_out,
    input  wire logic [`PPR_NUM_FIXED-1:0]        fixed_per_oe,
    output logic      [`PPR_NUM_FIXED-1:0]        fixed_out,
    output logic      [`PPR_NUM_FIXED-1:0]        fixed_oe,
    output logic      [`PPR_NUM_FIXED-1:0]        fixed_per_in
);

    ppr_lock_t                             lock_st;
    ppr_lock_t                             next_lock_st;
    ppr_sel_t  [`PPR_NUM_IN-1:0]           in_sel;
    ppr_sel_t  [`PPR_NUM_IN-1:0]           next_in_sel;
    logic      [`PPR_NUM_IN-1:0]           in_en;
    logic      [`PPR_NUM_IN-1:0]           next_in_en;
    ppr_sel_t  [`PPR_NUM_PINS-1:0]         out_sel;
    ppr_sel_t  [`PPR_NUM_PINS-1:0]         next_out_sel;
    logic                                  next_cfg_err;
    logic      [`PPR_NUM_PINS-1:0]         pin_meta;
    logic      [`PPR_NUM_PINS-1:0]         pin_sync;
    logic      [`PPR_NUM_FIXED-1:0]        fix_meta;
    logic      [`PPR_NUM_FIXED-1:0]        fix_sync;
    logic      [`PPR_NUM_PINS-1:0]         next_pin_out;
    logic      [`PPR_NUM_PINS-1:0]         next_pin_oe;
    logic      [`PPR_NUM_IN-1:0]           next_per_in;
    logic      [`PPR_NUM_FIXED-1:0]        next_fixed_out;
    logic      [`PPR_NUM_FIXED-1:0]        next_fixed_oe;
    logic      [`PPR_NUM_FIXED-1:0]        next_fixed_per_in;

    // protection: unlock needs two keys on back-to-back key strobes
    always_comb
    begin
        next_lock_st = lock_st;
        if (lock_set)
        begin
            next_lock_st = PPR_LOCKED;
        end
        else if (key_wr)
        begin
            case (lock_st)
                PPR_LOCKED:
                    if (key_val == `PPR_KEY_FIRST)
                        next_lock_st = PPR_KEY1;
                PPR_KEY1:
                    if (key_val == `PPR_KEY_SECOND)
                        next_lock_st = PPR_OPEN;
                    else
                        next_lock_st = PPR_LOCKED;
                default:
                    next_lock_st = lock_st;
            endcase
        end
        else if (lock_st == PPR_KEY1)
        begin
            // a gap between the keys aborts the unlock
            next_lock_st = PPR_LOCKED;
        end
    end

    // routing tables: inputs and outputs are written independently
    always_comb
    begin
        next_in_sel  = in_sel;
        next_in_en   = in_en;
        next_out_sel = out_sel;
        next_cfg_err = 1'b0;
        if (cfg_wr && lock_st != PPR_OPEN)
        begin
            next_cfg_err = 1'b1;
        end
        else if (cfg_wr && !cfg_dir)
        begin
            if (cfg_idx < `PPR_NUM_IN)
            begin
                next_in_sel[cfg_idx[2:0]] = cfg_val;
                next_in_en[cfg_idx[2:0]]  = 1'b1;
            end
            else
            begin
                next_cfg_err = 1'b1;
            end
        end
        else if (cfg_wr)
        begin
            next_out_sel[cfg_idx] = cfg_val;
        end
    end

    // per remappable pin: analog, then remapped output, then gpio
    genvar gp;
    generate
        for (gp = 0; gp < `PPR_NUM_PINS; gp++)
        begin : g_pin
            logic use_remap;
            assign use_remap = out_sel[gp] != `PPR_SEL_NONE &&
                               out_sel[gp] <= `PPR_NUM_OUT;
            always_comb
            begin
                if (pin_analog[gp])
                begin
                    next_pin_out[gp] = 1'b0;
                    next_pin_oe[gp]  = 1'b0;
                end
                else if (use_remap)
                begin
                    next_pin_out[gp] = per_out[out_sel[gp][2:0] - 3'h1];
                    next_pin_oe[gp]  = 1'b1;
                end
                else
                begin
                    next_pin_out[gp] = gpio_out[gp];
                    next_pin_oe[gp]  = gpio_oe[gp];
                end
            end
        end
    endgenerate

    // per peripheral input: unassigned or analog pins read low
    genvar gi;
    generate
        for (gi = 0; gi < `PPR_NUM_IN; gi++)
        begin : g_in
            always_comb
            begin
                next_per_in[gi] = in_en[gi] &&
                                  !pin_analog[in_sel[gi]] &&
                                  pin_sync[in_sel[gi]];
            end
        end
    endgenerate

    // dedicated pins never join the remap, analog still wins
    genvar gf;
    generate
        for (gf = 0; gf < `PPR_NUM_FIXED; gf++)
        begin : g_fix
            always_comb
            begin
                next_fixed_out[gf]    = !fixed_analog[gf] &&
                                        fixed_per_out[gf];
                next_fixed_oe[gf]     = !fixed_analog[gf] &&
                                        fixed_per_oe[gf];
                next_fixed_per_in[gf] = !fixed_analog[gf] && fix_sync[gf];
            end
        end
    endgenerate

    // registers; outputs leave straight from flops
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lock_st      <= PPR_OPEN;
            in_sel       <= '0;
            in_en        <= '0;
            out_sel      <= '0;
            cfg_err      <= 1'b0;
            cfg_locked   <= 1'b0;
            pin_meta     <= '0;
            pin_sync     <= '0;
            fix_meta     <= '0;
            fix_sync     <= '0;
            pin_out      <= '0;
            pin_oe       <= '0;
            per_in       <= '0;
            fixed_out    <= '0;
            fixed_oe     <= '0;
            fixed_per_in <= '0;
        end
        else
        begin
            lock_st      <= next_lock_st;
            in_sel       <= next_in_sel;
            in_en        <= next_in_en;
            out_sel      <= next_out_sel;
            cfg_err      <= next_cfg_err;
            cfg_locked   <= next_lock_st != PPR_OPEN;
            pin_meta     <= pin_in;
            pin_sync     <= pin_meta;
            fix_meta     <= fixed_in;
            fix_sync     <= fix_meta;
            pin_out      <= next_pin_out;
            pin_oe       <= next_pin_oe;
            per_in       <= next_per_in;
            fixed_out    <= next_fixed_out;
            fixed_oe     <= next_fixed_oe;
            fixed_per_in <= next_fixed_per_in;
        end
    end

    // checks on the design's own behaviour
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    a_err_on_lock: assert property (
        cfg_wr && lock_st != PPR_OPEN |=> cfg_err && $stable(in_sel)
            && $stable(out_sel))
        else $error("routing changed while locked");

    a_key_unlock: assert property (
        lock_st == PPR_LOCKED && !lock_set && key_wr
            && key_val == `PPR_KEY_FIRST
        ##1 !lock_set && key_wr && key_val == `PPR_KEY_SECOND
        |=> !cfg_locked && lock_st == PPR_OPEN)
        else $error("key pair did not unlock");

    a_lock_set: assert property (
        lock_set |=> cfg_locked)
        else $error("lock request ignored");

    a_no_default: assert property (
        !in_en[0] |=> !per_in[0])
        else $error("unassigned input not low");

    a_in_route: assert property (
        in_en[0] && !pin_analog[in_sel[0]]
        |=> per_in[0] == $past(pin_sync[in_sel[0]]))
        else $error("input not taken from selected pin");

    a_remap_wins: assert property (
        g_pin[0].use_remap && !pin_analog[0]
        |=> pin_oe[0] && pin_out[0] == $past(per_out[out_sel[0][2:0]
            - 3'h1]))
        else $error("remapped output lost priority");

    a_analog_wins: assert property (
        1'b1 |=> (pin_oe & $past(pin_analog)) == '0)
        else $error("analog pin driven digitally");

    a_fixed_pin: assert property (
        fixed_per_oe[0] && !fixed_analog[0]
        |=> fixed_oe[0] && fixed_out[0] == $past(fixed_per_out[0]))
        else $error("fixed peripheral not on its pin");

    a_tables_apart: assert property (
        cfg_wr && !cfg_dir |=> $stable(out_sel))
        else $error("input write touched output table");

    c_unlock: cover property (
        lock_st == PPR_KEY1 ##1 lock_st == PPR_OPEN);
    c_remap_out: cover property (g_pin[3].use_remap && pin_oe[3]);
    c_locked_write: cover property (cfg_err);

endmodule : ppr_remap

/* tb/ppr_far_model.sv */
// far-side model: remappable pins, peripheral outputs, dedicated pins
module ppr_far_model
(
    input  wire logic        core_clk,
    input  wire logic [15:0] pin_pat,
    input  wire logic [7:0]  per_pat,
    input  wire logic [1:0]  fix_pat,
    output logic      [15:0] pin_in = 16'h0000,
    output logic      [7:0]  per_out = 8'h00,
    output logic      [1:0]  fixed_in = 2'h0
);
    timeunit 1ns;
    timeprecision 1ps;

    // change only off the sampling edge, so no race with the design
    always @(negedge core_clk)
    begin
        pin_in   <= pin_pat;
        per_out  <= per_pat;
        fixed_in <= fix_pat;
    end
endmodule : ppr_far_model

/* tb/testbench.sv */
// self-checking bench for the peripheral pin remap block
`include "ppr_map.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    fail_count++; $display("Error %s exp %0h got %0h", nm, e, g); end end

module testbench;
    import ppr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk, rst_b = 0, cfg_wr = 0, cfg_dir = 0, key_wr = 0;
    logic lock_set = 0, cfg_locked, cfg_err, locked_m = 0;
    logic [3:0] cfg_idx = 0, cfg_val = 0;
    logic [7:0] key_val = 0, per_pat = 0, per_out, per_in, ien = 0;
    logic [15:0] pin_pat = 0, pin_in, pin_analog = 0, gpio_out = 0;
    logic [15:0] gpio_oe = 0, pin_out, pin_oe;
    logic [1:0] fix_pat = 0, fixed_in, fixed_analog = 0, fixed_per_out = 0;
    logic [1:0] fixed_per_oe = 0, fixed_out, fixed_oe, fixed_per_in;
    ppr_sel_t isel [8];
    ppr_sel_t osel [16];
    int fail_count = 0, checks_done = 0, cyc = 0, seed = 32'h8e6f;

    ppr_remap dut_u (.core_clk(core_clk), .rst_b(rst_b), .cfg_wr(cfg_wr),
        .cfg_dir(cfg_dir), .cfg_idx(cfg_idx), .cfg_val(cfg_val),
        .key_wr(key_wr), .key_val(key_val), .lock_set(lock_set),
        .cfg_locked(cfg_locked), .cfg_err(cfg_err), .pin_in(pin_in),
        .pin_analog(pin_analog), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .pin_out(pin_out), .pin_oe(pin_oe), .per_out(per_out),
        .per_in(per_in), .fixed_in(fixed_in), .fixed_analog(fixed_analog),
        .fixed_per_out(fixed_per_out), .fixed_per_oe(fixed_per_oe),
        .fixed_out(fixed_out), .fixed_oe(fixed_oe),
        .fixed_per_in(fixed_per_in));
    ppr_far_model far_u (.core_clk(core_clk), .pin_pat(pin_pat),
        .per_pat(per_pat), .fix_pat(fix_pat), .pin_in(pin_in),
        .per_out(per_out), .fixed_in(fixed_in));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // hang guard: whole run is about 620 cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    function automatic logic exp_oe(int p);
        if (pin_analog[p]) return 1'b0;
        if (osel[p] inside {[1:8]}) return 1'b1;
        return gpio_oe[p];
    endfunction : exp_oe

    function automatic logic exp_out(int p);
        if (osel[p] inside {[1:8]}) return per_out[osel[p] - 1];
        return gpio_out[p];
    endfunction : exp_out

    // unassigned or analog input reads zero
    function automatic logic exp_in(int i);
        return ien[i] & ~pin_analog[isel[i]] & pin_in[isel[i]];
    endfunction : exp_in

    // one write pulse; refused writes leave the bench tables alone
    task automatic cfg(input logic d, input logic [3:0] i, input logic [3:0] v);
        logic err_seen;
        @(negedge core_clk);
        {cfg_wr, cfg_dir, cfg_idx, cfg_val} = {1'b1, d, i, v};
        @(negedge core_clk);
        cfg_wr = 1'b0;
        err_seen = cfg_err;
        @(negedge core_clk);
        err_seen |= cfg_err;
        `CHK("cfg_err", locked_m | (~d & i[3]), err_seen)
        if (!locked_m && d) osel[i] = v;
        if (!locked_m && !d && !i[3])
        begin
            isel[i] = v;
            ien[i] = 1'b1;
        end
    endtask : cfg

    task automatic keys(input logic [7:0] k1, input logic [7:0] k2);
        @(negedge core_clk);
        {key_wr, key_val} = {1'b1, k1};
        @(negedge core_clk);
        key_val = k2;
        @(negedge core_clk);
        key_wr = 1'b0;
        if (k1 == `PPR_KEY_FIRST && k2 == `PPR_KEY_SECOND) locked_m = 1'b0;
    endtask : keys

    // fresh random pin, peripheral and analog levels
    task automatic shake();
        @(negedge core_clk);
        {pin_pat, per_pat, fix_pat} = 26'($random(seed));
        pin_analog = 16'($random(seed) & $random(seed));
        {gpio_out, gpio_oe} = $random(seed);
        {fixed_analog, fixed_per_out, fixed_per_oe} = 6'($random(seed));
    endtask : shake

    // wait out the 3-flop input path, then compare every output except cfg_err
    task automatic chk_all();
        repeat (5) @(negedge core_clk);
        for (int p = 0; p < 16; p++)
        begin
            `CHK("pin_oe", exp_oe(p), pin_oe[p])
            `CHK("pin_out", exp_oe(p) & exp_out(p), pin_oe[p] & pin_out[p])
        end
        for (int i = 0; i < 8; i++)
            `CHK("per_in", exp_in(i), per_in[i])
        `CHK("fixed_oe", fixed_per_oe & ~fixed_analog, fixed_oe)
        `CHK("fixed_out", fixed_per_oe & fixed_per_out & ~fixed_analog,
             fixed_oe & fixed_out)
        `CHK("fixed_per_in", fixed_in & ~fixed_analog, fixed_per_in)
        `CHK("cfg_locked", locked_m, cfg_locked)
    endtask : chk_all

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish

    initial
    begin
        logic [31:0] r;
        foreach (osel[p]) osel[p] = `PPR_SEL_RST;
        foreach (isel[i]) isel[i] = `PPR_SEL_RST;
        repeat (10) @(negedge core_clk);
        rst_b = 1'b1;
        `CHK("per_in_rst", 8'h00, per_in)
        shake();
        chk_all();
        // corners: select zero means pin 0, top codes, bad input index
        cfg(1'b0, 4'h2, 4'h5);
        cfg(1'b0, 4'h3, 4'h0);
        cfg(1'b0, 4'h7, 4'hF);
        cfg(1'b1, 4'hF, 4'h8);
        cfg(1'b1, 4'h0, 4'h1);
        cfg(1'b1, 4'h4, 4'h9);
        cfg(1'b0, 4'h8, 4'h1);
        shake();
        chk_all();
        repeat (60)
        begin
            r = $random(seed);
            cfg(r[4], r[3:0], r[11:8]);
            shake();
            chk_all();
        end
        // locked: writes refused, wrong or reversed keys keep the lock
        @(negedge core_clk);
        lock_set = 1'b1;
        locked_m = 1'b1;
        @(negedge core_clk);
        lock_set = 1'b0;
        cfg(1'b1, 4'h6, 4'h2);
        keys(`PPR_KEY_FIRST, 8'h00);
        cfg(1'b0, 4'h1, 4'h3);
        keys(`PPR_KEY_SECOND, `PPR_KEY_FIRST);
        shake();
        chk_all();
        keys(`PPR_KEY_FIRST, `PPR_KEY_SECOND);
        cfg(1'b1, 4'h6, 4'h2);
        shake();
        chk_all();
        // mid-run reset while locked: tables and lock start over
        @(negedge core_clk);
        lock_set = 1'b1;
        @(negedge core_clk);
        {lock_set, rst_b} = 2'b00;
        repeat (2) @(negedge core_clk);
        rst_b = 1'b1;
        `CHK("pin_oe_rst", 16'h0000, pin_oe)
        foreach (osel[p]) osel[p] = `PPR_SEL_RST;
        foreach (isel[i]) isel[i] = `PPR_SEL_RST;
        ien = 8'h00;
        locked_m = 1'b0;
        chk_all();
        tally_and_finish();
    end
endmodule : testbench
